// file: pkg/pmr_regs.vh
// Purpose: constants of the phy management register bank
// Assumes: included by bare name from the design files
// Notes: addresses are register numbers on the management frame
`ifndef PMR_REGS_VH
`define PMR_REGS_VH

// register addresses
`define PMR_REG_CONTROL 5'h00
`define PMR_REG_STATUS 5'h01
`define PMR_REG_IDENT_HIGH 5'h02
`define PMR_REG_IDENT_LOW 5'h03
`define PMR_REG_ADVERTISE 5'h04
`define PMR_REG_PARTNER 5'h05
`define PMR_REG_EXPANSION 5'h06

// reset values and masks
`define PMR_CONTROL_RESET 16'h3100
`define PMR_STATUS_FIXED 16'h7809
`define PMR_ADVERTISE_RESET 16'h01E1
`define PMR_ADVERTISE_WMASK 16'h3DFF

// control field positions
`define PMR_CTL_SOFT_RESET 15
`define PMR_CTL_LOOPBACK 14
`define PMR_CTL_SPEED 13
`define PMR_CTL_AN_ENABLE 12
`define PMR_CTL_POWER_DOWN 11
`define PMR_CTL_ISOLATE 10
`define PMR_CTL_AN_RESTART 9
`define PMR_CTL_DUPLEX 8
`define PMR_CTL_COL_TEST 7

// status field positions
`define PMR_STS_AN_DONE 5
`define PMR_STS_REMOTE_FAULT 4
`define PMR_STS_LINK 2
`define PMR_STS_JABBER 1

// management frame constants
`define PMR_PREAMBLE_BITS 6'h20
`define PMR_OP_READ 2'h2
`define PMR_OP_WRITE 2'h1
`define PMR_ADDR_LAST 4'h9
`define PMR_DATA_LAST 4'hF

`endif

// file: verilog/pmr_sync.v
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to ref_clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module pmr_sync #(
    parameter W = 2
) (
    // clock, reset, enable
    input wire ref_clk,
    input wire arst_n,
    input wire ce,
    // data
    input wire [W-1:0] d,
    output reg [W-1:0] q
);

reg [W-1:0] meta;

// two stage capture, frozen while ce is low
always @(posedge ref_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        meta <= {W{1'b0}};
        q <= {W{1'b0}};
    end
    else if (ce)
    begin
        meta <= d;
        q <= meta;
    end
end

endmodule // pmr_sync

// file: verilog/pmr_mgmt_regs.v
// Purpose: management register bank of a 10/100 phy behind mdc/mdio
// Assumes: mdc is far slower than ref_clk; status inputs are on ref_clk
// Notes: frames need a full 32 bit preamble before the start bits
// Function
// - seven 16-bit registers at management addresses 0 to 6
// - control register reads 3100h after reset
// - soft reset and autoneg restart bits act once and self-clear
// - control bit 14 enables loopback, resets to zero
// - autoneg enabled means bits 8 and 13 do not pick speed, duplex
// - control bit 7 enables collision test, resets to zero
// - status reads 7809h after reset, all bits read-only
// - status bit 15, t4 ability, always zero
// - status bits 14 to 11 and bit 3 always one
// - status bit 6 zero; frames without preamble are rejected
// - status bit 5 shows autoneg completion
// - status bit 4 latches remote fault until read or reset
// - status bit 2 shows link, latching low on any loss
// - status bit 1 latches high on jabber
// - status bit 0 always one, extended registers present
// - oui bits split over ident high and ident low 15:10, read-only
// - ident low holds model in 9:4, revision in 3:0
// - advertisement selector resets to 00001
`timescale 1ns/1ps
`include "pmr_regs.vh"
module pmr_mgmt_regs #(
    parameter [4:0] PHY_ADDR = 5'h01,
    parameter [15:0] OUI_HIGH = 16'h0A5C, // arbitrary value
    parameter [5:0] OUI_LOW = 6'h15, // arbitrary value
    parameter [5:0] MODEL = 6'h02, // arbitrary value
    parameter [3:0] REVISION = 4'h1 // arbitrary value
) (
    // clock, reset, enable
    input wire ref_clk,
    input wire arst_n,
    input wire ce,
    // management pins
    input wire mdc,
    input wire mdio_in,
    output reg mdio_out,
    output reg mdio_oe,
    // conditions from the phy core
    input wire an_done_in,
    input wire remote_fault_in,
    input wire link_ok_in,
    input wire jabber_in,
    input wire an_speed_100_in,
    input wire an_full_duplex_in,
    input wire [15:0] lp_ability_in,
    input wire [15:0] an_expansion_in,
    // controls to the phy core
    output reg soft_reset_pulse,
    output reg autoneg_restart_pulse,
    output reg loopback_en,
    output reg power_down,
    output reg isolate,
    output reg collision_test,
    output reg autoneg_enable,
    output reg link_speed_100,
    output reg link_full_duplex,
    output reg [15:0] advertise_word
);

localparam [15:0] CTRL_RST = `PMR_CONTROL_RESET;
localparam [5:0] ST_PRE = 6'b000001;
localparam [5:0] ST_START = 6'b000010;
localparam [5:0] ST_OP = 6'b000100;
localparam [5:0] ST_ADDR = 6'b001000;
localparam [5:0] ST_TA = 6'b010000;
localparam [5:0] ST_DATA = 6'b100000;

wire [1:0] pin_s;
wire mdc_s;
wire mdio_s;
reg mdc_d;
wire mdc_rise;
reg [5:0] state;
reg [5:0] pre_cnt;
reg [3:0] bit_cnt;
reg [1:0] op;
reg [8:0] addr_sh;
reg [4:0] reg_addr;
reg rd_go;
reg wr_go;
reg [15:0] rd_shift;
reg [14:0] wr_shift;
reg wr_stb;
reg [15:0] wr_data;
reg status_rd_stb;
reg speed_select;
reg duplex_select;
reg remote_fault_flag;
reg link_up_flag;
reg jabber_flag;
wire [9:0] addr_next;

// read value of one register, zero outside the bank
function [15:0] pmr_read_word;
    input [4:0] a;
    begin
        case (a)
            `PMR_REG_CONTROL:
                pmr_read_word = {1'b0, loopback_en, speed_select,
                    autoneg_enable, power_down, isolate, 1'b0,
                    duplex_select, collision_test, 7'h00};
            `PMR_REG_STATUS:
                pmr_read_word = `PMR_STATUS_FIXED
                    | ({15'h0000, an_done_in} << `PMR_STS_AN_DONE)
                    | ({15'h0000, remote_fault_flag} << `PMR_STS_REMOTE_FAULT)
                    | ({15'h0000, link_up_flag} << `PMR_STS_LINK)
                    | ({15'h0000, jabber_flag} << `PMR_STS_JABBER);
            `PMR_REG_IDENT_HIGH:
                pmr_read_word = OUI_HIGH;
            `PMR_REG_IDENT_LOW:
                pmr_read_word = {OUI_LOW, MODEL, REVISION};
            `PMR_REG_ADVERTISE:
                pmr_read_word = advertise_word;
            `PMR_REG_PARTNER:
                pmr_read_word = lp_ability_in;
            `PMR_REG_EXPANSION:
                pmr_read_word = an_expansion_in;
            default:
                pmr_read_word = 16'h0000;
        endcase
    end
endfunction

// pin synchronisers for mdc and mdio
pmr_sync #(
    .W(2)
) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .d({mdc, mdio_in}),
    .q(pin_s)
);

assign mdc_s = pin_s[1];
assign mdio_s = pin_s[0];
assign mdc_rise = mdc_s & ~mdc_d;
assign addr_next = {addr_sh, mdio_s};

// mdc edge finder
always @(posedge ref_clk or negedge arst_n)
begin
    if (!arst_n)
        mdc_d <= 1'b0;
    else if (ce)
        mdc_d <= mdc_s;
end

// management frame engine, one step per mdc rising edge
always @(posedge ref_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        state <= ST_PRE;
        pre_cnt <= 6'd0;
        bit_cnt <= 4'd0;
        op <= 2'b00;
        addr_sh <= 9'h000;
        reg_addr <= 5'h00;
        rd_go <= 1'b0;
        wr_go <= 1'b0;
        rd_shift <= 16'h0000;
        wr_shift <= 15'h0000;
        wr_stb <= 1'b0;
        wr_data <= 16'h0000;
        status_rd_stb <= 1'b0;
        mdio_out <= 1'b0;
        mdio_oe <= 1'b0;
    end
    else if (ce)
    begin
        wr_stb <= 1'b0;
        status_rd_stb <= 1'b0;
        if (mdc_rise)
        begin
            case (state)
                ST_PRE:
                begin
                    if (mdio_s)
                    begin
                        if (pre_cnt != `PMR_PREAMBLE_BITS)
                            pre_cnt <= pre_cnt + 6'd1;
                    end
                    else if (pre_cnt == `PMR_PREAMBLE_BITS)
                    begin
                        state <= ST_START;
                        pre_cnt <= 6'd0;
                    end
                    else
                        pre_cnt <= 6'd0; // short preamble: drop frame
                end
                ST_START:
                begin
                    bit_cnt <= 4'd0;
                    if (mdio_s)
                        state <= ST_OP;
                    else
                        state <= ST_PRE;
                end
                ST_OP:
                begin
                    op <= {op[0], mdio_s};
                    if (bit_cnt == 4'd1)
                    begin
                        state <= ST_ADDR;
                        bit_cnt <= 4'd0;
                    end
                    else
                        bit_cnt <= bit_cnt + 4'd1;
                end
                ST_ADDR:
                begin
                    addr_sh <= addr_next[8:0];
                    bit_cnt <= bit_cnt + 4'd1;
                    if (bit_cnt == `PMR_ADDR_LAST)
                    begin
                        bit_cnt <= 4'd0;
                        reg_addr <= addr_next[4:0];
                        rd_go <= (op == `PMR_OP_READ)
                            && (addr_next[9:5] == PHY_ADDR);
                        wr_go <= (op == `PMR_OP_WRITE)
                            && (addr_next[9:5] == PHY_ADDR);
                        rd_shift <= pmr_read_word(addr_next[4:0]);
                        // a status read releases the latched bits
                        status_rd_stb <= (op == `PMR_OP_READ)
                            && (addr_next[9:5] == PHY_ADDR)
                            && (addr_next[4:0] == `PMR_REG_STATUS);
                        if ((op == `PMR_OP_READ) || (op == `PMR_OP_WRITE))
                            state <= ST_TA;
                        else
                            state <= ST_PRE;
                    end
                end
                ST_TA:
                begin
                    if (bit_cnt == 4'd0)
                    begin
                        bit_cnt <= 4'd1;
                        mdio_oe <= rd_go; // second turnaround bit is zero
                        mdio_out <= 1'b0;
                    end
                    else
                    begin
                        bit_cnt <= 4'd0;
                        state <= ST_DATA;
                        if (rd_go)
                        begin
                            mdio_out <= rd_shift[15];
                            rd_shift <= {rd_shift[14:0], 1'b0};
                        end
                    end
                end
                ST_DATA:
                begin
                    wr_shift <= {wr_shift[13:0], mdio_s};
                    bit_cnt <= bit_cnt + 4'd1;
                    if (rd_go)
                    begin
                        mdio_out <= rd_shift[15];
                        rd_shift <= {rd_shift[14:0], 1'b0};
                    end
                    if (bit_cnt == `PMR_DATA_LAST)
                    begin
                        mdio_oe <= 1'b0;
                        mdio_out <= 1'b0;
                        rd_go <= 1'b0;
                        wr_go <= 1'b0;
                        wr_stb <= wr_go;
                        wr_data <= {wr_shift, mdio_s};
                        state <= ST_PRE;
                        pre_cnt <= 6'd0;
                        bit_cnt <= 4'd0;
                    end
                end
                default:
                begin
                    state <= ST_PRE;
                    pre_cnt <= 6'd0;
                    mdio_oe <= 1'b0;
                end
            endcase
        end
    end
end

// control and advertisement registers, written by management frames
always @(posedge ref_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        loopback_en <= CTRL_RST[`PMR_CTL_LOOPBACK];
        speed_select <= CTRL_RST[`PMR_CTL_SPEED];
        autoneg_enable <= CTRL_RST[`PMR_CTL_AN_ENABLE];
        power_down <= CTRL_RST[`PMR_CTL_POWER_DOWN];
        isolate <= CTRL_RST[`PMR_CTL_ISOLATE];
        duplex_select <= CTRL_RST[`PMR_CTL_DUPLEX];
        collision_test <= CTRL_RST[`PMR_CTL_COL_TEST];
        soft_reset_pulse <= 1'b0;
        autoneg_restart_pulse <= 1'b0;
        advertise_word <= `PMR_ADVERTISE_RESET;
    end
    else if (ce)
    begin
        soft_reset_pulse <= 1'b0;
        autoneg_restart_pulse <= 1'b0;
        if (wr_stb && (reg_addr == `PMR_REG_CONTROL))
        begin
            if (wr_data[`PMR_CTL_SOFT_RESET])
            begin
                // software reset restores defaults; the bit reads zero
                soft_reset_pulse <= 1'b1;
                loopback_en <= CTRL_RST[`PMR_CTL_LOOPBACK];
                speed_select <= CTRL_RST[`PMR_CTL_SPEED];
                autoneg_enable <= CTRL_RST[`PMR_CTL_AN_ENABLE];
                power_down <= CTRL_RST[`PMR_CTL_POWER_DOWN];
                isolate <= CTRL_RST[`PMR_CTL_ISOLATE];
                duplex_select <= CTRL_RST[`PMR_CTL_DUPLEX];
                collision_test <= CTRL_RST[`PMR_CTL_COL_TEST];
                advertise_word <= `PMR_ADVERTISE_RESET;
            end
            else
            begin
                loopback_en <= wr_data[`PMR_CTL_LOOPBACK];
                speed_select <= wr_data[`PMR_CTL_SPEED];
                autoneg_enable <= wr_data[`PMR_CTL_AN_ENABLE];
                power_down <= wr_data[`PMR_CTL_POWER_DOWN];
                isolate <= wr_data[`PMR_CTL_ISOLATE];
                duplex_select <= wr_data[`PMR_CTL_DUPLEX];
                collision_test <= wr_data[`PMR_CTL_COL_TEST];
                autoneg_restart_pulse <= wr_data[`PMR_CTL_AN_RESTART];
            end
        end
        // read-only bits of the advertisement keep their values
        if (wr_stb && (reg_addr == `PMR_REG_ADVERTISE))
            advertise_word <= (wr_data & `PMR_ADVERTISE_WMASK)
                | (advertise_word & ~`PMR_ADVERTISE_WMASK);
    end
end

// latched status bits; a new event wins over the read release
always @(posedge ref_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        remote_fault_flag <= 1'b0;
        link_up_flag <= 1'b0;
        jabber_flag <= 1'b0;
    end
    else if (ce)
    begin
        if (soft_reset_pulse)
        begin
            remote_fault_flag <= remote_fault_in;
            link_up_flag <= 1'b0;
            jabber_flag <= jabber_in;
        end
        else
        begin
            remote_fault_flag <= remote_fault_in
                | (remote_fault_flag & ~status_rd_stb);
            link_up_flag <= link_ok_in
                & (link_up_flag | status_rd_stb);
            jabber_flag <= jabber_in
                | (jabber_flag & ~status_rd_stb);
        end
    end
end

// resolved speed and duplex for the phy core
always @(posedge ref_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        link_speed_100 <= 1'b0;
        link_full_duplex <= 1'b0;
    end
    else if (ce)
    begin
        if (autoneg_enable)
        begin
            link_speed_100 <= an_speed_100_in;
            link_full_duplex <= an_full_duplex_in;
        end
        else
        begin
            link_speed_100 <= speed_select;
            link_full_duplex <= duplex_select;
        end
    end
end

endmodule // pmr_mgmt_regs

// file: test/pmr_station.sv
// Purpose: management station model driving mdc and mdio frames
// Assumes: mdio has a pull-up; mdc stands still between frames
// Notes: bits change with mdc low, read bits are sampled before each rise
`timescale 1ns/1ps
module pmr_station (
    // management pins
    output logic mdc,
    output logic st_out,
    output logic st_oe,
    input wire logic mdio
);
    // idle: clock low, wire released
    initial
    begin
        mdc = 1'b0;
        st_out = 1'b1;
        st_oe = 1'b0;
    end

    // one 400 ns mdc period; the wire is sampled just before the rise
    task automatic tick(input logic b, input logic drv, output logic s);
        st_out = b;
        st_oe = drv;
        #200;
        s = mdio;
        mdc = 1'b1;
        #200;
        mdc = 1'b0;
    endtask

    // one frame; pre plus the idle bit of the frame before below 32 makes the device drop the frame
    task automatic frame(input int pre, input logic wr, input logic [4:0] pa,
        input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hdr;
        logic [17:0] tail;
        logic s;
        hdr = {2'b01, (wr ? 2'b01 : 2'b10), pa, ra};
        tail = {2'b10, wd};
        repeat (pre) tick(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--)
            tick(hdr[i], 1'b1, s);
        // turnaround and data; on reads the station lets go of the wire
        for (int i = 17; i >= 0; i--)
        begin
            tick(tail[i], wr, s);
            if (i < 16)
                rd[i] = s;
        end
        tick(1'b1, 1'b0, s);
    endtask
endmodule // pmr_station

// file: test/pmr_monitor.sv
// Purpose: port checks on the phy management register bank
// Assumes: mdc is sampled here directly and is far slower than ref_clk
// Notes: bound to every pmr_mgmt_regs instance
`timescale 1ns/1ps
module pmr_monitor (
    // clock and reset
    input wire ref_clk,
    input wire arst_n,
    // management pins
    input wire mdc,
    input wire mdio_out,
    input wire mdio_oe,
    // phy core side
    input wire an_speed_100_in,
    input wire an_full_duplex_in,
    input wire soft_reset_pulse,
    input wire autoneg_restart_pulse,
    input wire loopback_en,
    input wire autoneg_enable,
    input wire link_speed_100,
    input wire link_full_duplex,
    input wire [15:0] advertise_word
);
    logic mdc_q;
    logic [5:0] oe_cnt;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // counts mdc rises while the device drives the wire
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mdc_q <= 1'b0;
            oe_cnt <= 6'h00;
        end
        else
        begin
            mdc_q <= mdc;
            if (!mdio_oe)
                oe_cnt <= 6'h00;
            else if (mdc && !mdc_q)
                oe_cnt <= oe_cnt + 6'h01;
        end
    end

    property p_sr_once;
        soft_reset_pulse |=> !soft_reset_pulse;
    endproperty
    a_sr_once: assert property (p_sr_once)
        else $error("soft reset pulse longer than one cycle");

    property p_ar_once;
        autoneg_restart_pulse |=> !autoneg_restart_pulse;
    endproperty
    a_ar_once: assert property (p_ar_once)
        else $error("restart pulse longer than one cycle");

    property p_ar_write;
        autoneg_restart_pulse |-> !mdio_oe && !soft_reset_pulse;
    endproperty
    a_ar_write: assert property (p_ar_write)
        else $error("restart pulse outside a plain write");

    property p_soft_def;
        soft_reset_pulse |-> ##[0:2] (autoneg_enable && !loopback_en
            && advertise_word == 16'h01E1);
    endproperty
    a_soft_def: assert property (p_soft_def)
        else $error("soft reset left control not at defaults");

    property p_an_speed;
        autoneg_enable [*3] |-> link_speed_100 == $past(an_speed_100_in);
    endproperty
    a_an_speed: assert property (p_an_speed)
        else $error("speed not from autoneg result");

    property p_an_duplex;
        autoneg_enable [*3] |-> link_full_duplex == $past(an_full_duplex_in);
    endproperty
    a_an_duplex: assert property (p_an_duplex)
        else $error("duplex not from autoneg result");

    property p_ta_zero;
        $rose(mdio_oe) |-> !mdio_out;
    endproperty
    a_ta_zero: assert property (p_ta_zero)
        else $error("turnaround bit not driven low");

    property p_oe_len;
        $fell(mdio_oe) |-> oe_cnt == 6'h11;
    endproperty
    a_oe_len: assert property (p_oe_len)
        else $error("read drive not 17 mdc periods long");

    property p_rst_vals;
        $rose(arst_n) |-> !mdio_oe && autoneg_enable && !loopback_en
            && advertise_word == 16'h01E1;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("outputs not at reset values");
endmodule // pmr_monitor

bind pmr_mgmt_regs pmr_monitor mon_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .mdc(mdc), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .an_speed_100_in(an_speed_100_in),
    .an_full_duplex_in(an_full_duplex_in),
    .soft_reset_pulse(soft_reset_pulse),
    .autoneg_restart_pulse(autoneg_restart_pulse),
    .loopback_en(loopback_en), .autoneg_enable(autoneg_enable),
    .link_speed_100(link_speed_100), .link_full_duplex(link_full_duplex),
    .advertise_word(advertise_word)
);

// file: test/pmr_mgmt_regs_tb.sv
// Purpose: self-checking bench for the phy management register bank
// Assumes: the station model runs mdc at 400 ns only inside frames
// Notes: inputs change at the falling edge of ref_clk
`timescale 1ns/1ps
module pmr_mgmt_regs_tb;
    localparam logic [4:0] PA = 5'h03;
    localparam logic [15:0] OH = 16'h1234; // arbitrary value
    logic ref_clk, arst_n, ce, mdc, mdio_in, mdio_out, mdio_oe;
    logic an_done_in, remote_fault_in, link_ok_in, jabber_in;
    logic an_speed_100_in, an_full_duplex_in, st_out, st_oe;
    logic soft_reset_pulse, autoneg_restart_pulse, loopback_en, power_down;
    logic isolate, collision_test, autoneg_enable, link_speed_100;
    logic link_full_duplex;
    logic [15:0] lp_ability_in, an_expansion_in, advertise_word, rv[8];
    int err_total, total_checks, cyc, n_sr, n_ar;
    // control outputs gathered for one compare
    wire [15:0] ctl = {9'h000, loopback_en, power_down, isolate,
        collision_test, autoneg_enable, link_speed_100, link_full_duplex};

    // wire level: station, then device, else the pull-up
    assign mdio_in = st_oe ? st_out : (mdio_oe ? mdio_out : 1'b1);

    // identity fields get arbitrary values
    pmr_mgmt_regs #(.PHY_ADDR(PA), .OUI_HIGH(OH), .OUI_LOW(6'h2A),
        .MODEL(6'h05), .REVISION(4'h3)) dut_u (
        .ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .mdc(mdc),
        .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .an_done_in(an_done_in), .remote_fault_in(remote_fault_in),
        .link_ok_in(link_ok_in), .jabber_in(jabber_in),
        .an_speed_100_in(an_speed_100_in),
        .an_full_duplex_in(an_full_duplex_in),
        .lp_ability_in(lp_ability_in), .an_expansion_in(an_expansion_in),
        .soft_reset_pulse(soft_reset_pulse),
        .autoneg_restart_pulse(autoneg_restart_pulse),
        .loopback_en(loopback_en), .power_down(power_down),
        .isolate(isolate), .collision_test(collision_test),
        .autoneg_enable(autoneg_enable), .link_speed_100(link_speed_100),
        .link_full_duplex(link_full_duplex), .advertise_word(advertise_word)
    );
    pmr_station st_u (.mdc(mdc), .st_out(st_out), .st_oe(st_oe),
        .mdio(mdio_in));

    // compare and count
    task automatic chk(input string nm, input logic [15:0] got, exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // write frame with a full preamble
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] x;
        st_u.frame(32, 1'b1, PA, ra, d, x);
    endtask

    // read frame compared with the expected word
    task automatic rdc(input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] x;
        st_u.frame(32, 1'b0, PA, ra, 16'h0000, x);
        chk("register read", x, exp);
    endtask

    // verdict and end of run
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // clock
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // pulse counts and the run time limit
    always @(posedge ref_clk)
    begin
        cyc++;
        if (soft_reset_pulse === 1'b1)
            n_sr++;
        if (autoneg_restart_pulse === 1'b1)
            n_ar++;
        if (cyc == 30000)
        begin
            err_total++;
            end_sim;
        end
    end

    initial
    begin
        logic [15:0] x;
        arst_n = 1'b0;
        ce = 1'b1;
        an_done_in = 1'b0;
        remote_fault_in = 1'b0;
        jabber_in = 1'b0;
        link_ok_in = 1'b1;
        an_speed_100_in = 1'b1;
        an_full_duplex_in = 1'b1;
        lp_ability_in = 16'hA5C3;
        an_expansion_in = 16'h0005;
        rv = '{16'h3100, 16'h7809, OH, 16'hA853, 16'h01E1, 16'hA5C3,
            16'h0005, 16'h0000};
        repeat (3) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        // whole map after reset; link flag low until the first read
        for (int i = 0; i < 8; i++)
            rdc(i[4:0], rv[i]);
        rdc(5'h1F, 16'h0000);
        rdc(5'h01, 16'h780D);
        // short fault, jabber and link loss ahead of the next read
        remote_fault_in = 1'b1;
        jabber_in = 1'b1;
        link_ok_in = 1'b0;
        an_done_in = 1'b1;
        repeat (3) @(negedge ref_clk);
        remote_fault_in = 1'b0;
        jabber_in = 1'b0;
        link_ok_in = 1'b1;
        rdc(5'h01, 16'h783B);
        rdc(5'h01, 16'h782D);
        // read-only and unmapped places ignore writes
        wr(5'h01, 16'h0000);
        rdc(5'h01, 16'h782D);
        wr(5'h02, 16'h0000);
        rdc(5'h02, OH);
        wr(5'h07, 16'hFFFF);
        rdc(5'h07, 16'h0000);
        // manual mode: bits 13 and 8 pick speed and duplex
        wr(5'h00, 16'h4C80);
        chk("control outputs", ctl, 16'h0078);
        rdc(5'h00, 16'h4C80);
        an_speed_100_in = 1'b0;
        an_full_duplex_in = 1'b0;
        wr(5'h00, 16'h2100);
        chk("control outputs", ctl, 16'h0003);
        // autoneg on: bits 13 and 8 are clear but the result wins
        an_speed_100_in = 1'b1;
        an_full_duplex_in = 1'b1;
        wr(5'h00, 16'h1000);
        chk("control outputs", ctl, 16'h0007);
        wr(5'h00, 16'h1200);
        rdc(5'h00, 16'h1000);
        chk("restart pulses", n_ar[15:0], 16'h0001);
        wr(5'h04, 16'h0041);
        chk("advertise", advertise_word, 16'h0041);
        wr(5'h00, 16'h8000);
        chk("soft reset pulses", n_sr[15:0], 16'h0001);
        // idle bit plus 30 gives 31 ones: the frame must be dropped
        st_u.frame(30, 1'b1, PA, 5'h00, 16'h4000, x);
        // another phy address: no write, wire left to the pull-up
        st_u.frame(32, 1'b1, 5'h04, 5'h00, 16'h4000, x);
        st_u.frame(32, 1'b0, 5'h04, 5'h00, 16'h0000, x);
        chk("foreign read", x, 16'hFFFF);
        rdc(5'h00, 16'h3100);
        rdc(5'h04, 16'h01E1);
        end_sim;
    end
endmodule // pmr_mgmt_regs_tb
